// File: bench/qadc_core_sva.sv
// Pin and bus timing checks for the converter serial port
module qadc_core_sva
	import qadc_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic rst, // Async reset, high
	input wire logic [3:0] address, // Byte address
	input wire logic read, // Read request
	input wire logic write, // Write request
	input wire logic [31:0] readdata, // Read data
	input wire logic waitrequest, // Stall
	input wire logic conversion_shift_clock, // Host shift clock
	input wire logic selectN, // Select, low
	input wire logic power_down_n, // Shutdown pin, low
	input wire logic serialOut, // Serial data out
	input wire logic serialOutOeN, // Out enable, low
	input wire logic busyOut, // Busy level
	input wire logic busyOeN, // Busy enable, low
	input wire logic shutdown // In shutdown
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence sReqStart;
		$rose(read || write);
	endsequence
	sequence sStallAnswer;
		waitrequest ##1 !waitrequest;
	endsequence
	a_bus_one_wait: assert property (sReqStart |-> sStallAnswer)
		else $error("bus answer not after one stall cycle");
	a_unmapped_zero: assert property (read && !waitrequest &&
		address == 4'h2 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	// Synchroniser delay is two edges, so four idle samples is ample
	a_out_released: assert property (selectN [*4] |-> serialOutOeN)
		else $error("serial out driven while deselected");
	a_busy_released: assert property (selectN [*4] |-> busyOeN)
		else $error("busy driven while deselected");
	a_out_on_fall: assert property ($changed(serialOut) && !serialOutOeN
		|-> !conversion_shift_clock)
		else $error("serial out moved while shift clock high");
	a_busy_on_rise: assert property ($rose(busyOut) |-> conversion_shift_clock)
		else $error("busy rose outside a high shift clock");
	a_busy_on_fall: assert property ($fell(busyOut) && !busyOeN
		|-> !conversion_shift_clock)
		else $error("busy fell outside a low shift clock");
	a_no_idle_busy: assert property (selectN [*4] |-> !$rose(busyOut))
		else $error("busy started while deselected");
	a_shut_pin: assert property (!power_down_n [*4] |-> shutdown)
		else $error("shutdown pin ignored");
	a_shut_quiet: assert property (shutdown [*3] |-> !busyOut)
		else $error("busy while shut down");
endmodule

bind qadc_core qadc_core_sva i_sva (.clock(clock), .rst(rst),
	.address(address), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest),
	.conversion_shift_clock(conversion_shift_clock), .selectN(selectN),
	.power_down_n(power_down_n), .serialOut(serialOut),
	.serialOutOeN(serialOutOeN), .busyOut(busyOut), .busyOeN(busyOeN),
	.shutdown(shutdown));

// File: bench/qadc_core_test.sv
// Self-checking bench for the converter serial port
module qadc_core_test
	import qadc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, rd;
	logic waitrequest, sclk, selN, din, serialOut, serialOutOeN;
	logic busyOut, busyOeN, shutdown;
	logic modePin = 1'b1;
	logic powerDownN = 1'b1;
	logic [11:0] got;
	qadc_word_t an [4] = '{12'h5a3, 12'h1c6, 12'he71, 12'h3bd};
	int err_total = 0;
	int tests_run = 0;
	always #2.5 clock = ~clock;
	qadc_core i_dut (.clock(clock), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.conversion_shift_clock(sclk), .selectN(selN), .serialIn(din),
		.power_down_n(powerDownN), .modePin(modePin), .analog_in_0(an[0]),
		.analog_in_1(an[1]), .analog_in_2(an[2]), .analog_in_3(an[3]),
		.serialOut(serialOut), .serialOutOeN(serialOutOeN),
		.busyOut(busyOut), .busyOeN(busyOeN), .shutdown(shutdown));
	qadc_host i_host (.sclk(sclk), .selN(selN), .din(din),
		.dout(serialOut), .doutOeN(serialOutOeN));
	// ****************************************
	// Tasks
	// ****************************************
	task stop_test;
		if (err_total == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	// The request stands until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task conv(input logic [7:0] cmd, input int nb, input logic [11:0] e);
		i_host.frame(cmd, nb, got);
		chk({20'h0, got}, {20'h0, e});
		bus(1'b0, 4'h8, 32'h0, rd);
		chk(rd, {20'h0, (nb == 8) ? {e[7:0], 4'h0} : e});
		// Done is set and the resolution flag shows the width used
		bus(1'b0, 4'h4, 32'h0, rd);
		chk(rd, (nb == 8) ? 32'hc : 32'h8);
		chk({31'h0, busyOeN}, 32'h1);
	endtask
	task pins(input logic m, input logic p);
		@(posedge clock);
		modePin <= m;
		powerDownN <= p;
		repeat (8) @(posedge clock);
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (8) @(posedge clock);
		chk({31'h0, shutdown}, 32'h0);
		bus(1'b0, 4'hc, 32'h0, rd);
		chk(rd, 32'h800);
		bus(1'b1, 4'hc, 32'ha5a, rd);
		bus(1'b0, 4'hc, 32'h0, rd);
		chk(rd, 32'ha5a);
		bus(1'b0, 4'h2, 32'h0, rd);
		chk(rd, 32'h0);
		for (int c = 0; c < 4; c++)
			conv({1'b1, c[0], 1'b0, c[1], 4'h7}, 12, an[c]);
		// Reading the status clears done
		bus(1'b0, 4'h4, 32'h0, rd);
		chk(rd, 32'h0);
		conv(8'hcf, 8, {4'h0, an[1][11:4]});
		pins(1'b0, 1'b1);
		conv(8'hdf, 12, an[3]);
		pins(1'b1, 1'b1);
		conv(8'h83, 12, an[0] - an[1]);
		pins(1'b1, 1'b0);
		chk({31'h0, shutdown}, 32'h1);
		i_host.frame(8'h87, 12, got);
		chk({20'h0, got}, 32'h0);
		bus(1'b0, 4'h8, 32'h0, rd);
		chk(rd, {20'h0, 12'(an[0] - an[1])});
		pins(1'b1, 1'b1);
		bus(1'b1, 4'h0, 32'h1, rd);
		bus(1'b0, 4'h0, 32'h0, rd);
		chk(rd, 32'h1);
		repeat (8) @(posedge clock);
		chk({31'h0, shutdown}, 32'h1);
		bus(1'b1, 4'h0, 32'h0, rd);
		repeat (8) @(posedge clock);
		chk({31'h0, shutdown}, 32'h0);
		stop_test;
	end
	// Eight frames take near 25 us; allow ample margin
	initial begin
		#200000;
		err_total++;
		stop_test;
	end
endmodule

// File: bench/qadc_host.sv
// Host controller model framing conversions on the serial pins
module qadc_host (
	output logic sclk, // Shift clock, low between frames
	output logic selN, // Select, low
	output logic din, // Serial data to device
	input wire logic dout, // Serial data from device
	input wire logic doutOeN // Device out enable, low
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b0;
		selN = 1'b1;
		din = 1'b0;
	end
	// Result bits are taken on rising edges from the ninth on
	task automatic frame(input logic [7:0] cmd, input int nb,
		output logic [11:0] got);
		logic line;
		got = 12'h000;
		#3.1 selN = 1'b0;
		for (int i = 1; i <= 24; i++) begin
			din = (i <= 8) ? cmd[8-i] : 1'b0;
			#62.5 sclk = 1'b1;
			// A released line shows no stale value
			line = doutOeN ? ~dout : dout;
			if (i >= 9 && i < 9 + nb)
				got = {got[10:0], line};
			#62.5 sclk = 1'b0;
		end
		#62.5 selN = 1'b1;
	endtask
endmodule

// File: hdl/qadc_avmm.sv
// Avalon-MM register slave of the converter serial port
`include "qadc_regs.svh"

module qadc_avmm
	import qadc_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic rst, // Async reset, high
	input wire logic [3:0] address, // Byte address
	input wire logic read, // Read request
	input wire logic write, // Write request
	input wire logic [31:0] writedata, // Write data
	input wire logic [3:0] byteenable, // Byte lanes
	output logic [31:0] readdata, // Read data
	output logic waitrequest, // Stall until answered
	output logic [1:0] ctrl, // Control bits to core
	input wire logic [3:0] status, // Core status bits
	input wire qadc_word_t result, // Last result
	input wire qadc_word_t sampleIn, // Stand-in analog level
	output qadc_word_t sample, // Analog level to core
	output logic doneClr // Clears sticky done
);
	logic ackReg;
	logic [1:0] ctrl_reg;
	qadc_word_t sample_reg;
	logic [31:0] readdata_reg;
	logic selCtrl;
	logic selStat;
	logic selRes;
	logic selSmp;
	logic [31:0] rdMux;
	logic access;
	logic commit;

	// ****************************************
	// Decode
	// ****************************************
	assign access = (read || write) && !ackReg;
	// Writes land at the edge where waitrequest is seen low
	assign commit = (read || write) && ackReg;
	assign selCtrl = (address == `QADC_OFS_CTRL);
	assign selStat = (address == `QADC_OFS_STATUS);
	assign selRes = (address == `QADC_OFS_RESULT);
	assign selSmp = (address == `QADC_OFS_SAMPLE);
	// Unmapped addresses read zero and ignore writes
	assign rdMux = selCtrl ? {30'h0, ctrl_reg} :
		selStat ? {28'h0, status} :
		selRes ? {20'h0, result} :
		selSmp ? {20'h0, sample_reg} : 32'h0;
	// One wait cycle: answer on the second edge of each request
	assign waitrequest = (read || write) && !ackReg;
	assign ctrl = ctrl_reg;
	assign sample = sample_reg;
	assign readdata = readdata_reg;
	assign doneClr = access && read && selStat;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ackReg <= 1'b0;
			ctrl_reg <= `QADC_CTRL_RST;
			sample_reg <= `QADC_SAMPLE_RST;
			readdata_reg <= 32'h0;
		end else begin
			ackReg <= access;
			if (access && read)
				readdata_reg <= rdMux;
			if (commit && write && selCtrl && byteenable[0])
				ctrl_reg <= writedata[1:0];
			if (commit && write && selSmp) begin
				if (byteenable[0])
					sample_reg[7:0] <= writedata[7:0];
				if (byteenable[1])
					sample_reg[11:8] <= writedata[11:8];
			end
		end
	end
endmodule

// File: hdl/qadc_core.sv
// Serial port and conversion sequencer of the four input converter
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`include "qadc_regs.svh"

// Overview of operation
// - Resolution is 8 or 12 bits, chosen by configuration each frame.
// - Inputs act as four single-ended or two differential pairs.
// - Conversions keep up to 200 kHz when the host clock allows.
// - Power-down low forces shutdown and stops all conversion activity.
// - Mode pin low forces every conversion to 12 bits.
// - Mode pin high takes resolution from the control byte bit.
// - Serial out changes on falling shift clock; released when deselected.
// - Busy is driven only while selected, released otherwise.
// - Serial input sampled on rising shift clock while selected.
// - Select frames each transfer; shift register works only when selected.
// - Host shift clock alone paces conversion steps and shifting.
module qadc_core
	import qadc_pkg::*;
(
	input wire logic clock, // System clock, 200 MHz
	input wire logic rst, // Async reset, high
	input wire logic [3:0] address, // Avalon byte address
	input wire logic read, // Avalon read
	input wire logic write, // Avalon write
	input wire logic [31:0] writedata, // Avalon write data
	input wire logic [3:0] byteenable, // Avalon byte lanes
	output logic [31:0] readdata, // Avalon read data
	output logic waitrequest, // Avalon stall
	input wire logic conversion_shift_clock, // Host shift clock pin
	input wire logic selectN, // Chip select pin, low
	input wire logic serialIn, // Serial data pin
	input wire logic power_down_n, // Shutdown pin, low
	input wire logic modePin, // Resolution mode pin
	input wire qadc_word_t analog_in_0, // Digitised level, input 0
	input wire qadc_word_t analog_in_1, // Digitised level, input 1
	input wire qadc_word_t analog_in_2, // Digitised level, input 2
	input wire qadc_word_t analog_in_3, // Digitised level, input 3
	output logic serialOut, // Serial data out
	output logic serialOutOeN, // Serial out enable, low
	output logic busyOut, // Busy level
	output logic busyOeN, // Busy enable, low
	output logic shutdown // Core in shutdown
);
	qadc_state_e state_reg;
	qadc_state_e state_next;
	logic [4:0] pinSync;
	logic sclk;
	logic selN;
	logic din;
	logic pdN;
	logic modeP;
	logic sclkPrev_reg;
	logic rise;
	logic fall;
	logic [7:0] cmd_reg;
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic res8_reg;
	qadc_word_t sar_reg;
	qadc_word_t held_reg;
	qadc_word_t trial;
	qadc_word_t result_reg;
	logic sout_reg;
	logic busy_reg;
	logic done_reg;
	logic [1:0] ctrl;
	qadc_word_t level;
	qadc_word_t regSample;
	logic doneClr;
	logic [4:0] nBits;
	logic [3:0] status;
	logic cmdDone;
	logic res8Pick;
	logic shutReq;
	logic inCmd;
	logic inConv;
	logic waitFirst;
	logic byteStart;
	logic shiftIn;
	logic trialKeep;
	logic convEnd;
	logic sarStep;
	logic busyNext;
	logic trackLevel;

	// ****************************************
	// Pin synchronisers and edge finding
	// ****************************************
	qadc_sync #(.W(5)) u_sync (
		.clock(clock),
		.rst(rst),
		.async({conversion_shift_clock, !selectN, serialIn, power_down_n,
			modePin}),
		.synced(pinSync)
	);
	assign sclk = pinSync[4];
	// Select passes inverted so the cleared flops read as deselected
	assign selN = !pinSync[3];
	assign din = pinSync[2];
	assign pdN = pinSync[1];
	assign modeP = pinSync[0];
	// Apart from select and shutdown, only the host clock edges step the sequencer
	// Edge latency of three clocks keeps up with the fastest frame rate
	assign rise = sclk && !sclkPrev_reg;
	assign fall = !sclk && sclkPrev_reg;

	// ****************************************
	// Register slave
	// ****************************************
	qadc_avmm u_regs (
		.clock(clock),
		.rst(rst),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.ctrl(ctrl),
		.status(status),
		.result(result_reg),
		.sampleIn(regSample),
		.sample(regSample),
		.doneClr(doneClr)
	);

	// ****************************************
	// Input selection
	// ****************************************
	// Bit 6 of the byte picks the odd input, bit 4 the upper pair
	function automatic qadc_word_t pickLevel(input logic [2:0] ch,
		input logic single, input qadc_word_t a0, input qadc_word_t a1,
		input qadc_word_t a2, input qadc_word_t a3);
		qadc_word_t pos;
		qadc_word_t neg;
		pos = ch[2] ? (ch[0] ? a3 : a1) : (ch[0] ? a2 : a0);
		neg = ch[2] ? (ch[0] ? a2 : a0) : (ch[0] ? a3 : a1);
		if (single)
			pickLevel = pos;
		else
			pickLevel = (pos > neg) ? 12'(pos - neg) : 12'h000;
	endfunction

	// Differential pairs are 0/1 and 2/3; a negative difference clips to zero
	assign level = pickLevel(cmd_reg[`QADC_CB_CH_MSB:`QADC_CB_CH_LSB],
		cmd_reg[`QADC_CB_SGL_BIT], analog_in_0, analog_in_1,
		analog_in_2, analog_in_3);

	// Mode pin low forces 12 bits, else the control byte picks
	// Read one place lower: the last byte bit is still in flight
	assign res8Pick = modeP &&
		cmd_reg[`QADC_CB_MODE_BIT - 1];
	assign nBits = res8_reg ? `QADC_BITS_8 : `QADC_BITS_12;
	assign trial = sar_reg | (12'h800 >> cnt_reg);
	assign cmdDone = rise && (cnt_reg == 5'({1'b0, `QADC_CB_BITS} - 5'h01));
	// Software can also hold the converter down
	assign shutReq = !pdN || ctrl[`QADC_CTRL_PD_BIT];
	assign status = {done_reg, res8_reg, shutReq, busy_reg};

	// ****************************************
	// Conversion decode
	// ****************************************
	assign inCmd = (state_reg == QADC_CMD);
	assign inConv = (state_reg == QADC_CONV);
	// Between the last command bit and the first falling edge
	assign waitFirst = inConv && (cnt_reg == 5'h00) && !fall;
	// A start bit seen in idle or right after a result opens a byte
	assign byteStart = (state_next == QADC_CMD) &&
		(state_reg == QADC_IDLE || state_reg == QADC_TAIL);
	assign shiftIn = inCmd && rise && !selN;
	// A trial bit stays when the level is at least the trial value
	assign trialKeep = (trial <= held_reg);
	assign sarStep = inConv && fall;
	assign convEnd = inConv && (state_next == QADC_TAIL);
	// The level tracks until the first falling edge after the byte, so the channel bits
	// are settled before the first trial
	assign trackLevel = inCmd || waitFirst;
	assign busyNext = (inCmd && cmdDone) || waitFirst;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			QADC_SHUT: begin
				if (!shutReq)
					state_next = QADC_IDLE;
			end
			QADC_IDLE: begin
				cnt_next = 5'h00;
				// Start bit: a high on din begins the control byte
				if (!selN && rise && din) begin
					state_next = QADC_CMD;
					cnt_next = 5'h01;
				end
			end
			QADC_CMD: begin
				if (rise) begin
					cnt_next = 5'(cnt_reg + 5'h01);
					if (cmdDone) begin
						state_next = QADC_CONV;
						cnt_next = 5'h00;
					end
				end
			end
			QADC_CONV: begin
				if (fall) begin
					cnt_next = 5'(cnt_reg + 5'h01);
					if (cnt_reg == 5'(nBits - 5'h01))
						state_next = QADC_TAIL;
				end
			end
			// A high on din at the next rise starts the next byte at once
			QADC_TAIL: begin
				if (rise && !din)
					state_next = QADC_IDLE;
				else if (rise)
					state_next = QADC_CMD;
				if (rise)
					cnt_next = 5'h01;
			end
			default: state_next = QADC_IDLE;
		endcase
		// Shutdown beats select, so a frame cannot wake the converter
		if (shutReq)
			state_next = QADC_SHUT;
		else if (selN)
			state_next = QADC_IDLE;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= QADC_SHUT;
			cnt_reg <= 5'h00;
			sclkPrev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sclkPrev_reg <= sclk;
		end
	end

	// ****************************************
	// Shift and successive approximation
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_reg <= 8'h00;
			res8_reg <= 1'b0;
			sar_reg <= 12'h000;
			held_reg <= 12'h000;
			result_reg <= 12'h000;
			done_reg <= 1'b0;
		end else begin
			if (byteStart)
				cmd_reg <= 8'h01;
			else if (shiftIn)
				cmd_reg <= {cmd_reg[6:0], din};
			// Resolution is fixed for the whole frame once the byte is in
			if (inCmd && cmdDone) begin
				res8_reg <= res8Pick;
				sar_reg <= 12'h000;
			end
			if (trackLevel)
				held_reg <= level;
			// One trial bit per falling edge
			if (sarStep)
				sar_reg <= trialKeep ? trial : sar_reg;
			if (convEnd) begin
				result_reg <= trialKeep ? trial : sar_reg;
				done_reg <= 1'b1;
			end else if (doneClr)
				done_reg <= 1'b0; // set above wins over the clear
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sout_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			// Held through the tail: the last bit stands until deselect or the next trial
			if (selN)
				sout_reg <= 1'b0;
			else if (sarStep)
				sout_reg <= trialKeep;
			busy_reg <= busyNext;
		end
	end

	// Pins released while deselected
	assign serialOut = sout_reg;
	assign serialOutOeN = selN;
	assign busyOut = busy_reg;
	assign busyOeN = selN;
	assign shutdown = (state_reg == QADC_SHUT);
endmodule

// File: hdl/qadc_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
module qadc_sync #(
	parameter int W = 1
) (
	input wire logic clock, // System clock
	input wire logic rst, // Async reset, high
	input wire logic [W-1:0] async, // Pin levels
	output logic [W-1:0] synced // Levels in clock domain
);
	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= async;
			stage2_reg <= stage1_reg;
		end
	end

	assign synced = stage2_reg;
endmodule

// File: pkg/qadc_pkg.sv
// Types shared by the converter serial port files
package qadc_pkg;
	typedef enum logic [2:0] {
		QADC_IDLE,
		QADC_CMD,
		QADC_CONV,
		QADC_TAIL,
		QADC_SHUT
	} qadc_state_e;

	typedef logic [11:0] qadc_word_t;
endpackage

// File: pkg/qadc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef QADC_REGS_SVH
`define QADC_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define QADC_OFS_CTRL 4'h0
`define QADC_OFS_STATUS 4'h4
`define QADC_OFS_RESULT 4'h8
`define QADC_OFS_SAMPLE 4'hc

// ****************************************
// Field positions
// ****************************************
`define QADC_CTRL_PD_BIT 0
`define QADC_CTRL_M8_BIT 1
`define QADC_STAT_BUSY_BIT 0
`define QADC_STAT_POWER_DOWN_N_BIT 1
`define QADC_STAT_RES8_BIT 2
`define QADC_STAT_DONE_BIT 3
`define QADC_CB_START_BIT 7
`define QADC_CB_CH_MSB 6
`define QADC_CB_CH_LSB 4
`define QADC_CB_MODE_BIT 3
`define QADC_CB_SGL_BIT 2
`define QADC_CB_PD_MSB 1
`define QADC_CB_PD_LSB 0

// ****************************************
// Reset values and timing
// ****************************************
`define QADC_CTRL_RST 2'h0
`define QADC_SAMPLE_RST 12'h800
`define QADC_BITS_12 5'h0c
`define QADC_BITS_8 5'h08
`define QADC_CB_BITS 4'h8
// Fastest conversion rate in kHz, and shift-clock periods per conversion frame
`define QADC_RATE_KHZ 200
`define QADC_FRAME_CLKS 24
`define QADC_CLK_MHZ 200
// System clocks per link clock period at the top rate
`define QADC_MIN_LINK_CYC ((`QADC_CLK_MHZ*1000)/(`QADC_RATE_KHZ*`QADC_FRAME_CLKS))

`endif
